// ---- burst_pkg.sv ----
package burst_pkg;
  // ************************************************************
  // Register map (byte addresses)
  // ************************************************************
  localparam logic [7:0] OFS_CONFIG = 8'h00;
  localparam logic [7:0] OFS_PRESET = 8'h04;
  localparam logic [7:0] OFS_DEAD = 8'h08;
  localparam logic [7:0] OFS_COMMAND = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_PERIOD = 8'h14;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int CFG_CODE_LSB = 0;
  localparam int CFG_CODE_W = 8;
  localparam int CFG_RANGE_BIT = 8;
  localparam int CFG_LIMIT_BIT = 9;
  localparam int CFG_LOWPWR_BIT = 10;
  localparam int PRE_ONE_LSB = 0;
  localparam int PRE_TWO_LSB = 8;
  localparam int PULSE_W = 5;
  localparam int DEAD_W = 12;
  localparam int CMD_START_BIT = 0;
  localparam int CMD_PRESET_BIT = 1;
  localparam int PERIOD_W = 16;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [7:0] RST_CODE = 8'h00;
  localparam logic [4:0] RST_PULSES = 5'h00;
  localparam logic [11:0] RST_DEAD = 12'h000;

  // ************************************************************
  // Frequency arithmetic and timing
  // ************************************************************
  localparam int DIV_W = 28;
  localparam logic [27:0] CORE_CLK_HZ = 28'd200000000;
  localparam logic [19:0] DRV_BASE_HZ = 20'd30000;
  localparam logic [19:0] DRV_STEP_HZ = 20'd200;
  localparam logic [7:0] CODE_MAX = 8'd200;
  localparam logic [2:0] RANGE_MULT = 3'd6;
  localparam logic [4:0] DIV_STEPS = 5'd28;
  localparam logic [2:0] POR_QUAL_CYCLES = 3'd4;
endpackage

// ---- drive_period_divider.sv ----
`timescale 1ns/1ps
`default_nettype none
module drive_period_divider (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic [27:0] divisor,
  output logic [15:0] period,
  output logic valid
);
  logic [27:0] rem_ff;
  logic [27:0] dvd_ff;
  logic [27:0] div_ff;
  logic [27:0] quo_ff;
  logic [4:0] step_ff;
  logic busy_ff;
  logic valid_ff;
  wire logic [28:0] rem_sh = {rem_ff, dvd_ff[27]};
  wire logic ge = rem_sh >= {1'b0, div_ff};
  wire logic [28:0] rem_sub = rem_sh - {1'b0, div_ff};
  wire logic [27:0] nxt_rem = ge ? rem_sub[27:0] : rem_sh[27:0];

  // Serial restoring divide: one quotient bit per clock saves a wide divider
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rem_ff <= '0;
      dvd_ff <= '0;
      div_ff <= '0;
      quo_ff <= '0;
      step_ff <= '0;
      busy_ff <= 1'b0;
      valid_ff <= 1'b0;
    end else if (start) begin
      rem_ff <= '0;
      dvd_ff <= burst_pkg::CORE_CLK_HZ;
      div_ff <= divisor;
      quo_ff <= '0;
      step_ff <= '0;
      busy_ff <= 1'b1;
      valid_ff <= 1'b0;
    end else if (busy_ff) begin
      rem_ff <= nxt_rem;
      dvd_ff <= {dvd_ff[26:0], 1'b0};
      quo_ff <= {quo_ff[26:0], ge};
      step_ff <= step_ff + 5'd1;
      busy_ff <= (step_ff != burst_pkg::DIV_STEPS - 5'd1);
      valid_ff <= (step_ff == burst_pkg::DIV_STEPS - 5'd1);
    end
  end

  assign period = quo_ff[15:0];
  assign valid = valid_ff;
endmodule
`default_nettype wire

// ---- power_sequencer.sv ----
`timescale 1ns/1ps
`default_nettype none
module power_sequencer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic low_power_req,
  input wire logic analog_reg_good,
  input wire logic interface_reg_good,
  input wire logic core_clock_running,
  output logic interface_reg_enable,
  output logic analog_reg_enable,
  output logic core_ready
);
  logic iface_en_ff;
  logic analog_en_ff;
  logic ready_ff;
  logic [2:0] qual_ff;
  wire logic all_good = analog_reg_good && interface_reg_good && core_clock_running
                        && analog_en_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      iface_en_ff <= 1'b0;
      analog_en_ff <= 1'b0;
      ready_ff <= 1'b0;
      qual_ff <= '0;
    end else begin
      iface_en_ff <= 1'b1; // [RULE11]
      analog_en_ff <= !low_power_req; // [RULE11]
      // Supplies must stay good for a few cycles; a glitch restarts the count
      if (!all_good || low_power_req) begin
        qual_ff <= '0;
        ready_ff <= 1'b0; // [RULE10]
      end else if (qual_ff != burst_pkg::POR_QUAL_CYCLES) begin
        qual_ff <= qual_ff + 3'd1;
      end else begin
        ready_ff <= 1'b1; // [RULE10]
      end
    end
  end

  assign interface_reg_enable = iface_en_ff;
  assign analog_reg_enable = analog_en_ff;
  assign core_ready = ready_ff;
endmodule
`default_nettype wire

// ---- ultrasonic_burst_generator.sv ----
// Behaviour
// RULE1: Drive frequency is 30 kHz plus 0.2 kHz*code.
// RULE2: Output period is core clock divided by ratio.
// RULE3: Nonzero count M gives exactly M pulse pairs.
// RULE4: Zero count pulses first output, second Hi-Z.
// RULE5: Range shift multiplies drive frequency by six.
// RULE6: Outputs alternate as complementary low-side switches.
// RULE7: Limit disable drives switches fully on.
// RULE8: Dead time shortens active part, period unchanged.
// RULE9: Software keeps dead time within period/8.
// RULE10: Hold reset until regulators and clock good.
// RULE11: Low power keeps interface regulator only.
// RULE12: Burst starts on command, ends with outputs off.
`timescale 1ns/1ps
`default_nettype none
module ultrasonic_burst_generator (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic analog_reg_good,
  input wire logic interface_reg_good,
  input wire logic core_clock_running,
  output logic interface_pin_regulator,
  output logic analog_reg_enable,
  output logic device_ready,
  output logic driver_out_first,
  output logic driver_out_second,
  output logic driver_second_oe_n,
  output logic limit_disable
);
  typedef enum logic [1:0] {
    st_idle,
    st_pairs,
    st_single
  } burst_state_t;

  // ************************************************************
  // Register state
  // ************************************************************
  logic [7:0] drive_code_a_ff;
  logic range_x6_select_ff;
  logic limit_disable_ff;
  logic low_power_ff;
  logic [4:0] first_preset_pulses_ff;
  logic [4:0] second_preset_pulses_ff;
  logic [11:0] dead_time_setting_ff;
  logic recalc_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;

  // ************************************************************
  // Burst state
  // ************************************************************
  burst_state_t state_ff;
  burst_state_t nxt_state;
  logic [15:0] period_ff;
  logic [11:0] dead_ff;
  logic [15:0] phase_ff;
  logic [4:0] pairs_left_ff;
  logic last_preset_ff;
  logic first_on_ff;
  logic second_on_ff;
  logic second_oe_n_ff;
  logic refused_ff;
  logic period_ok_ff;

  wire logic [15:0] div_period;
  wire logic div_valid;
  wire logic core_ready;
  wire logic iface_en;
  wire logic analog_en;

  // ************************************************************
  // Helpers
  // ************************************************************
  // Full-width compare; partial decode would alias one write onto two registers
  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction

  // ************************************************************
  // APB decode
  // ************************************************************
  wire logic access = psel && penable;
  wire logic commit = access && pready_ff;
  wire logic hit_config = addr_hit(paddr, burst_pkg::OFS_CONFIG);
  wire logic hit_preset = addr_hit(paddr, burst_pkg::OFS_PRESET);
  wire logic hit_dead = addr_hit(paddr, burst_pkg::OFS_DEAD);
  wire logic hit_command = addr_hit(paddr, burst_pkg::OFS_COMMAND);
  wire logic hit_status = addr_hit(paddr, burst_pkg::OFS_STATUS);
  wire logic hit_period = addr_hit(paddr, burst_pkg::OFS_PERIOD);
  wire logic mapped = hit_config || hit_preset || hit_dead || hit_command
                      || hit_status || hit_period;
  wire logic wr_config = commit && pwrite && hit_config;
  wire logic wr_preset = commit && pwrite && hit_preset;
  wire logic wr_dead = commit && pwrite && hit_dead;
  wire logic wr_command = commit && pwrite && hit_command;

  // Codes above the top of the table are clamped rather than wrapped
  wire logic [7:0] wr_code = pwdata[burst_pkg::CFG_CODE_LSB +: burst_pkg::CFG_CODE_W];
  wire logic [7:0] clamp_code = (wr_code > burst_pkg::CODE_MAX) ? burst_pkg::CODE_MAX : wr_code;
  wire logic cfg_changes = wr_config && ((clamp_code != drive_code_a_ff)
                           || (pwdata[burst_pkg::CFG_RANGE_BIT] != range_x6_select_ff));

  // ************************************************************
  // Drive frequency in Hz
  // ************************************************************
  wire logic [19:0] step_hz = 20'(drive_code_a_ff * burst_pkg::DRV_STEP_HZ);
  wire logic [19:0] base_drive_code_a = burst_pkg::DRV_BASE_HZ + step_hz; // [RULE1]
  wire logic [22:0] shifted_drive_code_a = 23'(base_drive_code_a * burst_pkg::RANGE_MULT); // [RULE5]
  wire logic [27:0] drive_drive_code_a = range_x6_select_ff ? {5'h00, shifted_drive_code_a}
                                                     : {8'h00, base_drive_code_a};

  drive_period_divider u_divider (
    .pclk(pclk),
    .presetn(presetn),
    .start(recalc_ff),
    .divisor(drive_drive_code_a),
    .period(div_period),
    .valid(div_valid)
  );

  power_sequencer u_power (
    .pclk(pclk),
    .presetn(presetn),
    .low_power_req(low_power_ff),
    .analog_reg_good(analog_reg_good),
    .interface_reg_good(interface_reg_good),
    .core_clock_running(core_clock_running),
    .interface_reg_enable(iface_en),
    .analog_reg_enable(analog_en),
    .core_ready(core_ready)
  );

  // ************************************************************
  // Burst command and pulse shaping
  // ************************************************************
  wire logic cmd_start = wr_command && pwdata[burst_pkg::CMD_START_BIT];
  wire logic cmd_preset = pwdata[burst_pkg::CMD_PRESET_BIT];
  wire logic can_start = (state_ff == st_idle) && period_ok_ff && core_ready
                         && !recalc_ff;
  wire logic go = cmd_start && can_start;
  wire logic [4:0] chosen_pulses = cmd_preset ? second_preset_pulses_ff
                                              : first_preset_pulses_ff;
  wire logic [15:0] half = {1'b0, period_ff[15:1]};
  wire logic [15:0] dead_ext = {4'h0, dead_ff};
  wire logic [15:0] active_len = (half > dead_ext) ? half - dead_ext : 16'h0000; // [RULE8]
  wire logic in_second = phase_ff >= half;
  wire logic [15:0] half_phase = in_second ? phase_ff - half : phase_ff;
  wire logic active = half_phase < active_len; // [RULE8]
  wire logic period_end = phase_ff == period_ff - 16'h0001; // [RULE2]
  wire logic last_pair = pairs_left_ff == 5'h01;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      st_idle: begin
        if (go) begin
          nxt_state = (chosen_pulses == 5'h00) ? st_single : st_pairs; // [RULE12]
        end
      end
      st_pairs: begin
        if (period_end && last_pair) begin
          nxt_state = st_idle; // [RULE3]
        end
      end
      st_single: begin
        if (period_end) begin
          nxt_state = st_idle; // [RULE4]
        end
      end
      default: begin
        nxt_state = st_idle;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= st_idle;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Period and dead time are frozen per burst so writes cannot tear a pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      period_ff <= 16'h0000;
      dead_ff <= burst_pkg::RST_DEAD;
      phase_ff <= 16'h0000;
      pairs_left_ff <= 5'h00;
      last_preset_ff <= 1'b0;
    end else if (go) begin
      period_ff <= div_period; // [RULE2]
      dead_ff <= dead_time_setting_ff;
      phase_ff <= 16'h0000;
      pairs_left_ff <= chosen_pulses; // [RULE3]
      last_preset_ff <= cmd_preset;
    end else if (state_ff != st_idle) begin
      phase_ff <= period_end ? 16'h0000 : phase_ff + 16'h0001;
      if (period_end && state_ff == st_pairs) begin
        pairs_left_ff <= pairs_left_ff - 5'h01; // [RULE3]
      end
    end
  end

  // Outputs are one cycle behind the phase counter, which keeps them glitch free
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_on_ff <= 1'b0;
      second_on_ff <= 1'b0;
      second_oe_n_ff <= 1'b1;
    end else begin
      case (state_ff)
        st_pairs: begin
          first_on_ff <= !in_second && active; // [RULE6]
          second_on_ff <= in_second && active; // [RULE6]
          second_oe_n_ff <= 1'b0;
        end
        st_single: begin
          first_on_ff <= !in_second && active; // [RULE4]
          second_on_ff <= 1'b0;
          second_oe_n_ff <= 1'b1; // [RULE4]
        end
        default: begin
          // Idle holds the second pin driven off rather than floating
          first_on_ff <= 1'b0; // [RULE12]
          second_on_ff <= 1'b0; // [RULE12]
          second_oe_n_ff <= 1'b0;
        end
      endcase
    end
  end

  // ************************************************************
  // Register writes
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_code_a_ff <= burst_pkg::RST_CODE;
      range_x6_select_ff <= 1'b0;
      limit_disable_ff <= 1'b0;
      low_power_ff <= 1'b0;
      first_preset_pulses_ff <= burst_pkg::RST_PULSES;
      second_preset_pulses_ff <= burst_pkg::RST_PULSES;
      dead_time_setting_ff <= burst_pkg::RST_DEAD;
    end else begin
      if (wr_config) begin
        drive_code_a_ff <= clamp_code; // [RULE1]
        range_x6_select_ff <= pwdata[burst_pkg::CFG_RANGE_BIT]; // [RULE5]
        limit_disable_ff <= pwdata[burst_pkg::CFG_LIMIT_BIT]; // [RULE7]
        low_power_ff <= pwdata[burst_pkg::CFG_LOWPWR_BIT]; // [RULE11]
      end
      if (wr_preset) begin
        first_preset_pulses_ff <= pwdata[burst_pkg::PRE_ONE_LSB +: burst_pkg::PULSE_W];
        second_preset_pulses_ff <= pwdata[burst_pkg::PRE_TWO_LSB +: burst_pkg::PULSE_W];
      end
      if (wr_dead) begin
        // Not range checked: keeping it within an eighth of the period is up to software
        dead_time_setting_ff <= pwdata[burst_pkg::DEAD_W-1:0];
      end
    end
  end

  // Recompute the ratio once after reset and after any frequency change
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      recalc_ff <= 1'b1;
      period_ok_ff <= 1'b0;
      refused_ff <= 1'b0;
    end else begin
      recalc_ff <= cfg_changes;
      if (recalc_ff) begin
        period_ok_ff <= 1'b0;
      end else if (div_valid) begin
        period_ok_ff <= 1'b1;
      end
      // Set wins over the clearing read of the status word
      if (cmd_start && !can_start) begin
        refused_ff <= 1'b1;
      end else if (commit && !pwrite && hit_status) begin
        refused_ff <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Read words
  // ************************************************************
  // Status is live; busy and pairs left follow the burst as it runs
  wire logic busy = state_ff != st_idle;
  wire logic single_run = state_ff == st_single;
  wire logic [31:0] rd_config = {21'h000000, low_power_ff, limit_disable_ff,
                                 range_x6_select_ff, drive_code_a_ff};
  wire logic [31:0] rd_preset = {19'h00000, second_preset_pulses_ff, 3'h0,
                                 first_preset_pulses_ff};
  wire logic [31:0] rd_dead = {20'h00000, dead_time_setting_ff};
  wire logic [31:0] rd_status = {19'h00000, pairs_left_ff, 2'h0, refused_ff,
                                 last_preset_ff, period_ok_ff, core_ready,
                                 single_run, busy};
  wire logic [31:0] rd_period = {16'h0000, div_period};
  wire logic [31:0] rd_mux = hit_config ? rd_config :
                             hit_preset ? rd_preset :
                             hit_dead ? rd_dead :
                             hit_status ? rd_status :
                             hit_period ? rd_period : 32'h00000000;

  // ************************************************************
  // APB answer: one wait state, data registered
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      prdata_ff <= 32'h00000000;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff <= access && !pready_ff;
      prdata_ff <= (access && !pready_ff && !pwrite) ? rd_mux : 32'h00000000;
      pslverr_ff <= access && !pready_ff && !mapped;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign interface_pin_regulator = iface_en;
  assign analog_reg_enable = analog_en;
  assign device_ready = core_ready;
  assign driver_out_first = first_on_ff;
  assign driver_out_second = second_on_ff;
  assign driver_second_oe_n = second_oe_n_ff;
  assign limit_disable = limit_disable_ff; // [RULE7]
endmodule
`default_nettype wire

// ---- ultrasonic_burst_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module ultrasonic_burst_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic analog_reg_good,
  input wire logic interface_reg_good,
  input wire logic core_clock_running,
  input wire logic interface_pin_regulator,
  input wire logic analog_reg_enable,
  input wire logic device_ready,
  input wire logic driver_out_first,
  input wire logic driver_out_second,
  input wire logic driver_second_oe_n,
  input wire logic limit_disable
);
  // ************
  // Pulse run lengths
  // ************
  logic [15:0] run_a_ff;
  logic [15:0] run_b_ff;
  logic last_a_ff;
  logic last_b_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_a_ff <= 16'h0000;
      run_b_ff <= 16'h0000;
      last_a_ff <= 1'b0;
      last_b_ff <= 1'b0;
    end else begin
      last_a_ff <= driver_out_first;
      last_b_ff <= driver_out_second;
      if (driver_out_first) run_a_ff <= last_a_ff ? run_a_ff + 16'h0001 : 16'h0001;
      if (driver_out_second) run_b_ff <= last_b_ff ? run_b_ff + 16'h0001 : 16'h0001;
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_ready_single: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_idle_read_zero: assert property (!pready |-> prdata == 32'h00000000)
    else $error("prdata nonzero outside answer");
  a_no_overlap: assert property (!(driver_out_first && driver_out_second))
    else $error("both low-side switches on");
  a_float_quiet: assert property (driver_second_oe_n |-> !driver_out_second)
    else $error("second switch on while released");
  a_ready_cause: assert property ($rose(device_ready) |->
    $past(analog_reg_good) && $past(interface_reg_good) && $past(core_clock_running))
    else $error("device ready without good supplies");
  a_drive_ready: assert property (driver_out_first |-> device_ready)
    else $error("drive before device ready");
  a_iface_on: assert property ($past(presetn) |-> interface_pin_regulator)
    else $error("interface regulator off");
  a_pair_equal: assert property ($fell(driver_out_second) |-> run_b_ff == run_a_ff)
    else $error("pair halves differ in width");
  c_pair: cover property ($fell(driver_out_second));
  c_single: cover property ($rose(driver_second_oe_n));
  c_err: cover property (pslverr);
  c_ready: cover property ($rose(device_ready));
endmodule
bind ultrasonic_burst_generator ultrasonic_burst_chk u_chk (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .analog_reg_good(analog_reg_good), .interface_reg_good(interface_reg_good),
  .core_clock_running(core_clock_running), .interface_pin_regulator(interface_pin_regulator),
  .analog_reg_enable(analog_reg_enable), .device_ready(device_ready),
  .driver_out_first(driver_out_first), .driver_out_second(driver_out_second),
  .driver_second_oe_n(driver_second_oe_n), .limit_disable(limit_disable)
);
`default_nettype wire

// ---- transducer_load.sv ----
`timescale 1ns/1ps
`default_nettype none
module transducer_load (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic drv_a,
  input wire logic drv_b,
  input wire logic drv_b_oe_n,
  output logic pin_b_level,
  output logic [7:0] pairs,
  output logic [7:0] singles,
  output logic [15:0] period,
  output logic [15:0] width
);
  // ************
  // Primary winding
  // ************
  logic [15:0] cyc;
  logic [15:0] hcnt;
  logic la;
  logic lb;
  // Center tap pulls a released pin up to supply
  assign pin_b_level = !(drv_b && !drv_b_oe_n);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {pairs, singles, period, width, cyc, hcnt, la} <= '0;
      // Released pin idles high, so no false pair at reset release
      lb <= 1'b1;
    end else begin
      la <= drv_a;
      lb <= pin_b_level;
      cyc <= (drv_a && !la) ? 16'h0001 : cyc + 16'h0001;
      if (drv_a && !la) period <= cyc;
      if (drv_a) hcnt <= la ? hcnt + 16'h0001 : 16'h0001;
      if (!drv_a && la) width <= hcnt;
      if (pin_b_level && !lb) pairs <= pairs + 8'h01;
      if (!drv_a && la && drv_b_oe_n) singles <= singles + 8'h01;
    end
  end
endmodule
`default_nettype wire

// ---- testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
  typedef struct {logic [31:0] e; logic [31:0] m; logic err;} note_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic a_good = 1'b0;
  logic i_good = 1'b0;
  logic c_run = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, iface_on, an_en, dev_rdy, out_a, out_b, b_oe_n, lim_dis, pin_b;
  logic [7:0] pairs, singles, p0, s0;
  logic [15:0] per, wid;
  logic [31:0] seed = 32'h830bb841;
  logic [31:0] rd_val, m, dt, n;
  logic [7:0] codes [4] = '{8'h00, 8'hc8, 8'hfa, 8'h00};
  note_t q[$];
  note_t nt;
  int error_cnt = 0;
  int compares = 0;
  int cyc = 0;
  always #2.5 pclk = ~pclk;
  ultrasonic_burst_generator u_ultrasonic_burst_generator (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .analog_reg_good(a_good), .interface_reg_good(i_good), .core_clock_running(c_run),
    .interface_pin_regulator(iface_on), .analog_reg_enable(an_en), .device_ready(dev_rdy),
    .driver_out_first(out_a), .driver_out_second(out_b), .driver_second_oe_n(b_oe_n),
    .limit_disable(lim_dis));
  transducer_load u_transducer_load (.pclk(pclk), .presetn(presetn), .drv_a(out_a),
    .drv_b(out_b), .drv_b_oe_n(b_oe_n), .pin_b_level(pin_b), .pairs(pairs),
    .singles(singles), .period(per), .width(wid));
  // ************
  // Helpers
  // ************
  function logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function logic [31:0] per_exp(input logic [7:0] c, input logic r);
    logic [31:0] f;
    f = 32'h7530 + 32'hc8 * ((c > 8'hc8) ? 32'hc8 : {24'h0, c});
    if (r) f = f * 32'h6;
    return 32'hbebc200 / f;
  endfunction
  task check(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) error_cnt++;
    rd_val = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] mk, input logic err);
    q.push_back('{e, mk, err});
    apb(a, 1'b0, 32'h0);
  endtask
  task poll(input int b, input logic v);
    int k;
    k = 0;
    do begin
      rd(burst_pkg::OFS_STATUS, 32'h0, 32'h0, 1'b0);
      k++;
    end while (rd_val[b] !== v && k < 5000);
    if (k >= 5000) error_cnt++;
  endtask
  task give_verdict;
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && q.size() > 0) begin
      nt = q.pop_front();
      if (nt.m != 32'h0) check("prdata", nt.e & nt.m, prdata & nt.m);
      check("pslverr", {31'h0, nt.err}, {31'h0, pslverr});
    end
  end
  // Ceiling covers the longest bursts run, 5 pairs at code 0xc8
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 60000) begin
      error_cnt++;
      give_verdict();
    end
  end
  // ************
  // Scenarios
  // ************
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    i_good <= 1'b1;
    c_run <= 1'b1;
    repeat (20) @(posedge pclk);
    check("ready", 32'h0, {31'h0, dev_rdy});
    check("iface", 32'h1, {31'h0, iface_on});
    a_good <= 1'b1;
    repeat (8) @(posedge pclk);
    check("ready", 32'h1, {31'h0, dev_rdy});
    $display("test power done");
    rd(burst_pkg::OFS_CONFIG, 32'h0, 32'hffffffff, 1'b0);
    rd(burst_pkg::OFS_PRESET, 32'h0, 32'hffffffff, 1'b0);
    rd(burst_pkg::OFS_DEAD, 32'h0, 32'hffffffff, 1'b0);
    rd(8'h20, 32'h0, 32'hffffffff, 1'b1);
    $display("test map done");
    codes[3] = xs() % 32'hc9;
    for (int i = 0; i < 8; i++) begin
      wr_cfg(codes[i / 2], i[0]);
      rd(burst_pkg::OFS_PERIOD, per_exp(codes[i / 2], i[0]), 32'hffff, 1'b0);
    end
    apb(burst_pkg::OFS_PERIOD, 1'b1, 32'hffff);
    rd(burst_pkg::OFS_PERIOD, per_exp(codes[3], 1'b1), 32'hffff, 1'b0);
    $display("test frequency done");
    wr_cfg(8'hc8, 1'b0);
    n = per_exp(8'hc8, 1'b0);
    m = xs() % 32'h4 + 32'h2;
    dt = xs() % (n / 32'h8 + 32'h1);
    apb(burst_pkg::OFS_DEAD, 1'b1, dt);
    apb(burst_pkg::OFS_PRESET, 1'b1, {19'h0, m[4:0], 8'h03});
    p0 = pairs;
    apb(burst_pkg::OFS_COMMAND, 1'b1, 32'h3);
    poll(0, 1'b0);
    check("pairs", m, {24'h0, pairs - p0});
    check("period", n, {16'h0, per});
    check("width", n / 32'h2 - dt, {16'h0, wid});
    check("idle", 32'h0, {30'h0, out_a, out_b});
    $display("test burst done");
    apb(burst_pkg::OFS_PRESET, 1'b1, {19'h0, m[4:0], 8'h00});
    p0 = pairs;
    s0 = singles;
    apb(burst_pkg::OFS_COMMAND, 1'b1, 32'h1);
    apb(burst_pkg::OFS_COMMAND, 1'b1, 32'h1);
    rd(burst_pkg::OFS_STATUS, 32'h23, 32'h23, 1'b0);
    poll(0, 1'b0);
    check("singles", 32'h1, {24'h0, singles - s0});
    check("pairs", 32'h0, {24'h0, pairs - p0});
    $display("test single done");
    apb(burst_pkg::OFS_CONFIG, 1'b1, 32'h2c8);
    repeat (2) @(posedge pclk);
    check("limit", 32'h1, {31'h0, lim_dis});
    apb(burst_pkg::OFS_CONFIG, 1'b1, 32'h4c8);
    repeat (2) @(posedge pclk);
    check("analog", 32'h0, {31'h0, an_en});
    check("iface", 32'h1, {31'h0, iface_on});
    $display("test power modes done");
    give_verdict();
  end
  task wr_cfg(input logic [7:0] c, input logic r);
    apb(burst_pkg::OFS_CONFIG, 1'b1, {23'h0, r, c});
    poll(3, 1'b1);
  endtask
endmodule
`default_nettype wire
